// file: rtl/adw_map.svh
// register offsets, field positions and reset values of the adc regs
`ifndef ADW_MAP_SVH
`define ADW_MAP_SVH
// register indices; byte address is four times the index
`define ADW_IDX_CTRL      6'h00
`define ADW_IDX_ACCUM     6'h02
`define ADW_IDX_MODE      6'h04
`define ADW_IDX_INSEL     6'h06
`define ADW_IDX_EVCTL     6'h09
`define ADW_IDX_IRQEN     6'h0A
`define ADW_IDX_FLAGS     6'h0B
`define ADW_IDX_DBG       6'h0C
`define ADW_IDX_TEMP      6'h0D
`define ADW_IDX_RES_LO    6'h10
`define ADW_IDX_RES_HI    6'h11
`define ADW_IDX_WLO_LO    6'h12
`define ADW_IDX_WLO_HI    6'h13
`define ADW_IDX_WHI_LO    6'h14
`define ADW_IDX_WHI_HI    6'h15
// field positions
`define ADW_BIT_ENABLE    0
`define ADW_BIT_START_EI  0
`define ADW_BIT_RDY       0
`define ADW_BIT_WIN       1
`define ADW_BIT_RUN       0
// reset values
`define ADW_RST_BYTE      8'h00
`define ADW_RST_WORD      16'h0000
`define ADW_RST_MODE      3'h0
`define ADW_RST_INSEL     5'h00
`define ADW_RST_ACCUM     3'h0
// code limits and accumulation
`define ADW_CODE_MAX      10'h3FF
`define ADW_CODE_MIN      10'h000
`define ADW_ACC_LOG_MAX   3'h6
`endif

// file: rtl/adw_pkg.sv
// types shared by the adc result and window register block
package adw_pkg;
  typedef enum logic [1:0] {
    ADW_IDLE = 2'b00,
    ADW_BUSY = 2'b01
  } adw_state_type;
  typedef enum logic [2:0] {
    ADW_WIN_OFF     = 3'h0,
    ADW_WIN_BELOW   = 3'h1,
    ADW_WIN_ABOVE   = 3'h2,
    ADW_WIN_INSIDE  = 3'h3,
    ADW_WIN_OUTSIDE = 3'h4
  } adw_win_mode_type;
  typedef struct packed {
    logic       valid;
    logic       over;
    logic       under;
    logic [9:0] code;
  } adw_sample_type;
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } adw_ahb_req_type;
endpackage

// file: rtl/adw_regs.sv
// adc result, window compare and control registers on an ahb-lite slave
//
// Notes on behaviour
// - event starts a conversion only while event_start_enable is set
// - irq_enable bit 1 gates the window_hit interrupt request
// - irq_enable bit 0 gates the result_ready interrupt request
// - window_hit flag set when result meets selected window condition
// - window_hit cleared only by software writing one; zero is ignored
// - result_ready flag set when a conversion completes
// - result, window_hit and result_ready update together when enabled
// - result_ready cleared only by writing one; zero write does nothing
// - run_while_halted keeps block running while cpu halted in debug
// - one shared temp byte serves every 16-bit register
// - temp byte is readable and writable at its own address
// - result low byte at base, high byte at base plus one, read only
// - single code clamps to 0x3FF when over-driven, zero when under
// - 16-bit accumulator holds up to 64 results without overflow
// - result and thresholds are unsigned, zero lowest, all ones full
// - single conversion gives ten-bit code in result bits 9:0
// - window compare done once on final accumulated value
// - 16-bit read-write low threshold as low and high byte
// - 16-bit read-write high threshold as low and high byte
// - mode 0 off, 1 below, 2 above, 3 inside, 4 outside, rest none
// - input selection change waits until running conversion completes
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "adw_map.svh"

module adw_regs (
  input  wire logic                     I_CLK,
  input  wire logic                     I_RST,
  input  wire adw_pkg::adw_ahb_req_type I_AHB,
  input  wire logic [31:0]              I_HWDATA,
  output logic [31:0]                   O_HRDATA,
  output logic                          O_HREADYOUT,
  output logic                          O_HRESP,
  input  wire logic                     I_EVENT,
  input  wire logic                     I_DEBUG_HALT,
  input  wire adw_pkg::adw_sample_type  I_SAMPLE,
  output logic                          O_CONV_START,
  output logic                          O_CONV_FREEZE,
  output logic [4:0]                    O_INPUT_SELECT,
  output logic                          O_IRQ_RESULT,
  output logic                          O_IRQ_WINDOW
);
  import adw_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic             adc_enable_reg;
  logic [2:0]       accum_log_reg;
  adw_win_mode_type window_mode_select_reg;
  logic [4:0]       input_select_reg;
  logic [4:0]       input_active_reg;
  logic             event_start_enable_reg;
  logic [1:0]       irq_enable_reg;
  logic             result_ready_reg;
  logic             window_hit_reg;
  logic             run_while_halted_reg;
  logic [7:0]       wide_access_byte_reg;
  logic [15:0]      conversion_result_reg;
  logic [15:0]      window_low_limit_reg;
  logic [15:0]      window_high_limit_reg;
  adw_state_type    state_reg;
  logic [15:0]      acc_reg;
  logic [6:0]       count_reg;

  // ****************************************
  // bus slave
  // ****************************************
  logic       wr_pend_reg;
  logic [5:0] wr_idx_reg;
  logic       rd_wait_reg;
  logic [5:0] rd_idx_reg;
  logic       take;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // reads cost one wait state so pending writes are always visible
  assign take = I_AHB.hsel & I_AHB.htrans[1] & I_AHB.hready;
  assign O_HREADYOUT = ~rd_wait_reg;
  assign O_HRESP = 1'b0;
  assign wr_en = wr_pend_reg;
  assign rd_en = rd_wait_reg;
  assign wbyte = I_HWDATA[7:0];

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 6'h00;
      rd_wait_reg <= 1'b0;
      rd_idx_reg  <= 6'h00;
    end else begin
      wr_pend_reg <= take & I_AHB.hwrite;
      rd_wait_reg <= take & ~I_AHB.hwrite;
      if (take) begin
        wr_idx_reg <= I_AHB.haddr[7:2];
        rd_idx_reg <= I_AHB.haddr[7:2];
      end
    end
  end

  // read mux; high bytes of 16-bit pairs come from the temp byte
  always_comb begin
    rbyte = 8'h00;
    unique case (rd_idx_reg)
      `ADW_IDX_CTRL:   rbyte = {7'h00, adc_enable_reg};
      `ADW_IDX_ACCUM:  rbyte = {5'h00, accum_log_reg};
      `ADW_IDX_MODE:   rbyte = {5'h00, window_mode_select_reg};
      `ADW_IDX_INSEL:  rbyte = {3'h0, input_select_reg};
      `ADW_IDX_EVCTL:  rbyte = {7'h00, event_start_enable_reg};
      `ADW_IDX_IRQEN:  rbyte = {6'h00, irq_enable_reg};
      `ADW_IDX_FLAGS:  rbyte = {6'h00, window_hit_reg, result_ready_reg};
      `ADW_IDX_DBG:    rbyte = {7'h00, run_while_halted_reg};
      `ADW_IDX_TEMP:   rbyte = wide_access_byte_reg;
      `ADW_IDX_RES_LO: rbyte = conversion_result_reg[7:0];
      `ADW_IDX_WLO_LO: rbyte = window_low_limit_reg[7:0];
      `ADW_IDX_WHI_LO: rbyte = window_high_limit_reg[7:0];
      `ADW_IDX_RES_HI,
      `ADW_IDX_WLO_HI,
      `ADW_IDX_WHI_HI: rbyte = wide_access_byte_reg;
      default:         rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      O_HRDATA <= {24'h00_0000, rbyte};
    end
  end

  // ****************************************
  // plain control registers
  // ****************************************
  // one process per register keeps each write decode easy to audit
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      adc_enable_reg <= 1'b0;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_CTRL)) begin
      adc_enable_reg <= wbyte[`ADW_BIT_ENABLE];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      accum_log_reg <= `ADW_RST_ACCUM;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_ACCUM)) begin
      accum_log_reg <= wbyte[2:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      window_mode_select_reg <= ADW_WIN_OFF;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_MODE)) begin
      window_mode_select_reg <= adw_win_mode_type'(wbyte[2:0]);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      input_select_reg <= `ADW_RST_INSEL;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_INSEL)) begin
      input_select_reg <= wbyte[4:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      event_start_enable_reg <= 1'b0;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_EVCTL)) begin
      event_start_enable_reg <= wbyte[`ADW_BIT_START_EI];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_enable_reg <= 2'b00;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_IRQEN)) begin
      irq_enable_reg <= wbyte[1:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      run_while_halted_reg <= 1'b0;
    end else if (wr_en && (wr_idx_reg == `ADW_IDX_DBG)) begin
      run_while_halted_reg <= wbyte[`ADW_BIT_RUN];
    end
  end

  // ****************************************
  // shared temp byte and 16-bit pairs
  // ****************************************
  // a low read in the wait cycle never meets a write, the bus forbids it
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wide_access_byte_reg <= `ADW_RST_BYTE;
    end else if (rd_en) begin
      unique case (rd_idx_reg)
        `ADW_IDX_RES_LO:
          wide_access_byte_reg <= conversion_result_reg[15:8];
        `ADW_IDX_WLO_LO:
          wide_access_byte_reg <= window_low_limit_reg[15:8];
        `ADW_IDX_WHI_LO:
          wide_access_byte_reg <= window_high_limit_reg[15:8];
        default: ;
      endcase
    end else if (wr_en) begin
      unique case (wr_idx_reg)
        `ADW_IDX_TEMP,
        `ADW_IDX_WLO_LO,
        `ADW_IDX_WHI_LO: wide_access_byte_reg <= wbyte;
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      window_low_limit_reg  <= `ADW_RST_WORD;
      window_high_limit_reg <= `ADW_RST_WORD;
    end else if (wr_en) begin
      unique case (wr_idx_reg)
        `ADW_IDX_WLO_HI:
          window_low_limit_reg <= {wbyte, wide_access_byte_reg};
        `ADW_IDX_WHI_HI:
          window_high_limit_reg <= {wbyte, wide_access_byte_reg};
        default: ;
      endcase
    end
  end

  // ****************************************
  // conversion sequencing
  // ****************************************
  logic        running;
  logic        start;
  logic [9:0]  code;
  logic [15:0] acc_next;
  logic [6:0]  target;
  logic        done;

  // frozen only while halted and not told to keep running
  assign running = ~I_DEBUG_HALT | run_while_halted_reg;
  assign O_CONV_FREEZE = ~running;
  assign start = I_EVENT & event_start_enable_reg & adc_enable_reg
               & running & (state_reg == ADW_IDLE);

  always_comb begin
    if (I_SAMPLE.over) begin
      code = `ADW_CODE_MAX;
    end else if (I_SAMPLE.under) begin
      code = `ADW_CODE_MIN;
    end else begin
      code = I_SAMPLE.code;
    end
  end

  // 64 x 0x3FF fits 16 bits, so plain sum cannot wrap
  assign acc_next = acc_reg + {6'h00, code};
  // reserved sample counts fall back to the largest, 64
  assign target = (accum_log_reg > `ADW_ACC_LOG_MAX)
                ? 7'h40 : 7'(7'h01 << accum_log_reg);
  assign done = (state_reg == ADW_BUSY) & I_SAMPLE.valid & running
              & adc_enable_reg & (count_reg + 7'h01 == target);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg    <= ADW_IDLE;
      acc_reg      <= `ADW_RST_WORD;
      count_reg    <= 7'h00;
      O_CONV_START <= 1'b0;
    end else begin
      O_CONV_START <= start;
      unique case (state_reg)
        ADW_IDLE: begin
          if (start) begin
            state_reg <= ADW_BUSY;
            acc_reg   <= `ADW_RST_WORD;
            count_reg <= 7'h00;
          end
        end
        ADW_BUSY: begin
          if (!adc_enable_reg) begin
            state_reg <= ADW_IDLE;
          end else if (I_SAMPLE.valid && running) begin
            acc_reg   <= acc_next;
            count_reg <= count_reg + 7'h01;
            if (done) begin
              state_reg <= ADW_IDLE;
            end
          end
        end
        default: state_reg <= ADW_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      conversion_result_reg <= `ADW_RST_WORD;
    end else if (done) begin
      conversion_result_reg <= acc_next;
    end
  end

  // mux moves only between conversions
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      input_active_reg <= `ADW_RST_INSEL;
    end else if (state_reg == ADW_IDLE || done) begin
      input_active_reg <= input_select_reg;
    end
  end
  assign O_INPUT_SELECT = input_active_reg;

  // ****************************************
  // window compare and flags
  // ****************************************
  logic win_match;
  logic clr_rdy;
  logic clr_win;

  // compare only the finished sum, never a single sample
  always_comb begin
    unique case (window_mode_select_reg)
      ADW_WIN_BELOW:
        win_match = acc_next < window_low_limit_reg;
      ADW_WIN_ABOVE:
        win_match = acc_next > window_high_limit_reg;
      ADW_WIN_INSIDE:
        win_match = (acc_next > window_low_limit_reg)
                  & (acc_next < window_high_limit_reg);
      ADW_WIN_OUTSIDE:
        win_match = ~((acc_next > window_low_limit_reg)
                    & (acc_next < window_high_limit_reg));
      default: win_match = 1'b0;
    endcase
  end

  assign clr_rdy = wr_en & (wr_idx_reg == `ADW_IDX_FLAGS)
                 & wbyte[`ADW_BIT_RDY];
  assign clr_win = wr_en & (wr_idx_reg == `ADW_IDX_FLAGS)
                 & wbyte[`ADW_BIT_WIN];

  // set beats a clear landing in the same cycle
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      result_ready_reg <= 1'b0;
    end else if (done) begin
      result_ready_reg <= 1'b1;
    end else if (clr_rdy) begin
      result_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      window_hit_reg <= 1'b0;
    end else if (done && win_match) begin
      window_hit_reg <= 1'b1;
    end else if (clr_win) begin
      window_hit_reg <= 1'b0;
    end
  end

  assign O_IRQ_RESULT = result_ready_reg & irq_enable_reg[0];
  assign O_IRQ_WINDOW = window_hit_reg & irq_enable_reg[1];

endmodule // adw_regs

// file: verif/adw_regs_monitor.sv
// assertion checker bound to the adc register block
`timescale 1ns/1ps
module adw_regs_monitor (
  input wire logic                     I_CLK,
  input wire logic                     I_RST,
  input wire adw_pkg::adw_ahb_req_type I_AHB,
  input wire logic [31:0]              O_HRDATA,
  input wire logic                     O_HREADYOUT,
  input wire logic                     O_HRESP,
  input wire logic                     I_EVENT,
  input wire logic                     I_DEBUG_HALT,
  input wire logic                     O_CONV_START,
  input wire logic                     O_CONV_FREEZE,
  input wire logic                     O_IRQ_RESULT,
  input wire logic                     O_IRQ_WINDOW
);
  import adw_pkg::*;
  logic tk;
  logic wtk;
  assign tk = I_AHB.hsel && I_AHB.htrans[1] && I_AHB.hready;
  assign wtk = tk && I_AHB.hwrite;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  a_start_pulse: assert property (O_CONV_START |=> !O_CONV_START)
    else $error("start longer than one cycle");
  a_start_cause: assert property (O_CONV_START |-> $past(I_EVENT))
    else $error("start without event");
  a_frozen_drop: assert property
    (I_EVENT && O_CONV_FREEZE |=> !O_CONV_START) else $error("frozen start");
  a_freeze_halt: assert property (O_CONV_FREEZE |-> I_DEBUG_HALT)
    else $error("freeze without halt");
  a_ready_hold: assert property
    ($fell(O_IRQ_RESULT) |-> $past(wtk, 2)) else $error("ready lost");
  a_hit_hold: assert property
    ($fell(O_IRQ_WINDOW) |-> $past(wtk, 2)) else $error("hit lost");
  a_read_wait: assert property
    (tk && !I_AHB.hwrite |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read wait wrong");
  a_write_fast: assert property (wtk |=> O_HREADYOUT)
    else $error("write stalled");
  a_high_zero: assert property (O_HRDATA[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_resp_okay: assert property (O_HRESP == 1'b0)
    else $error("bus response not okay");
endmodule // adw_regs_monitor
bind adw_regs adw_regs_monitor u_mon (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_AHB(I_AHB), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP),
  .I_EVENT(I_EVENT), .I_DEBUG_HALT(I_DEBUG_HALT),
  .O_CONV_START(O_CONV_START), .O_CONV_FREEZE(O_CONV_FREEZE),
  .O_IRQ_RESULT(O_IRQ_RESULT), .O_IRQ_WINDOW(O_IRQ_WINDOW));

// file: verif/adw_conv_model.sv
// converter model: answers each start with a burst of samples
`timescale 1ns/1ps
module adw_conv_model (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_start,
  input  wire logic                    i_freeze,
  input  wire logic [6:0]              i_count,
  input  wire adw_pkg::adw_sample_type i_value,
  output adw_pkg::adw_sample_type      o_sample
);
  import adw_pkg::*;
  logic [6:0] left_reg;
  logic       gap_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      left_reg <= 7'h00;
      gap_reg <= 1'b0;
      o_sample <= '0;
    end else begin
      gap_reg <= ~gap_reg;
      // idle code toggles so a stale value never looks valid
      o_sample.code <= ~o_sample.code;
      o_sample.valid <= 1'b0;
      if (i_start) begin
        left_reg <= i_count;
      end else if (left_reg != 7'h00 && gap_reg && !i_freeze) begin
        o_sample <= i_value;
        o_sample.valid <= 1'b1;
        left_reg <= left_reg - 7'h01;
      end
    end
  end
endmodule // adw_conv_model

// file: verif/tb_adw_regs.sv
// self-checking bench of the adc result and window register block
`timescale 1ns/1ps
`include "adw_map.svh"
module tb_adw_regs;
  import adw_pkg::*;
  // ****
  // signals
  // ****
  localparam int LIMIT = 40000;
  localparam logic [5:0] RW_IDX [4] = '{`ADW_IDX_EVCTL, `ADW_IDX_IRQEN,
                                        `ADW_IDX_DBG, `ADW_IDX_TEMP};
  localparam logic [7:0] RW_MSK [4] = '{8'h01, 8'h03, 8'h01, 8'hFF};
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            sel = 1'b0;
  logic            wr = 1'b0;
  logic            ev = 1'b0;
  logic            halt = 1'b0;
  logic [1:0]      trans = 2'h0;
  logic [31:0]     addr = 32'h0000_0000;
  logic [31:0]     wdata = 32'h0000_0000;
  logic [6:0]      count = 7'h00;
  adw_sample_type  value = '0;
  adw_sample_type  sample;
  adw_ahb_req_type ahb;
  logic [31:0]     rdata, got;
  logic            ready, start, freeze, irq_r, irq_w, hit_exp;
  logic [4:0]      insel, sel_exp = 5'h00;
  logic [15:0]     lo, hi, v;
  int              fail_count = 0;
  int              num_checks = 0;
  int              cycles = 0;
  assign ahb = {sel, addr, trans, wr, 3'h2, ready};
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      finish_test();
    end
  end
  adw_regs dut (.I_CLK(clk), .I_RST(rst), .I_AHB(ahb), .I_HWDATA(wdata),
    .O_HRDATA(rdata), .O_HREADYOUT(ready), .O_HRESP(), .I_EVENT(ev),
    .I_DEBUG_HALT(halt), .I_SAMPLE(sample), .O_CONV_START(start),
    .O_CONV_FREEZE(freeze), .O_INPUT_SELECT(insel), .O_IRQ_RESULT(irq_r),
    .O_IRQ_WINDOW(irq_w));
  adw_conv_model u_conv (.i_clk(clk), .i_rst(rst), .i_start(start),
    .i_freeze(freeze), .i_count(count), .i_value(value), .o_sample(sample));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t value %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t flag %b want %b", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    sel <= 1'b1;
    trans <= 2'h2;
    wr <= w;
    addr <= {24'h00_0000, i, 2'b00};
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    sel <= 1'b0;
    trans <= 2'h0;
    wdata <= {24'h00_0000, d};
    do @(negedge clk); while (ready !== 1'b1);
    got = rdata;
    @(posedge clk);
  endtask
  task automatic wr16(input logic [5:0] i, input logic [15:0] d);
    bus(1'b1, i, d[7:0]);
    bus(1'b1, i + 6'h01, d[15:8]);
  endtask
  task automatic rd16(input logic [5:0] i);
    bus(1'b0, i, 8'h00);
    v[7:0] = got[7:0];
    bus(1'b0, i + 6'h01, 8'h00);
    v[15:8] = got[7:0];
  endtask
  task automatic pulse_ev(input logic e);
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    #1;
    chk_bit(start, e);
  endtask
  function automatic logic [15:0] exp_sum(adw_sample_type s, int n);
    logic [9:0] c;
    c = s.over ? `ADW_CODE_MAX : (s.under ? `ADW_CODE_MIN : s.code);
    return 16'(n * c);
  endfunction
  function automatic logic exp_hit(logic [2:0] m, logic [15:0] r);
    case (m)
      3'h1: return r < lo;
      3'h2: return r > hi;
      3'h3: return r > lo && r < hi;
      3'h4: return !(r > lo && r < hi);
      default: return 1'b0;
    endcase
  endfunction
  // accumulate counts of 4 and above keep the select write inside the conversion
  task automatic conv(input logic [2:0] m, input logic [2:0] lg);
    int n;
    logic [4:0] nxt;
    n = (lg == 3'h7) ? 64 : (1 << lg);
    nxt = 5'($urandom);
    count <= 7'(n);
    value <= 13'($urandom);
    bus(1'b1, `ADW_IDX_FLAGS, 8'h03);
    bus(1'b1, `ADW_IDX_ACCUM, 8'(lg));
    bus(1'b1, `ADW_IDX_MODE, 8'(m));
    pulse_ev(1'b1);
    bus(1'b1, `ADW_IDX_INSEL, 8'(nxt));
    if (n >= 4) chk(32'(insel), 32'(sel_exp));
    for (int k = 0; k < 400 && irq_r !== 1'b1; k++) @(negedge clk);
    // a select landing on the completion edge shows one cycle later
    @(negedge clk);
    sel_exp = nxt;
    chk(32'(insel), 32'(sel_exp));
    chk_bit(irq_r, 1'b1);
    hit_exp = exp_hit(m, exp_sum(value, n));
    rd16(`ADW_IDX_RES_LO);
    chk(32'(v), 32'(exp_sum(value, n)));
    chk_bit(irq_w, hit_exp);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(2));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 9; i < 22; i++) begin
      bus(1'b0, 6'(i), 8'h00);
      chk(got, 32'h0000_0000);
    end
    for (int i = 0; i < 8; i++) begin
      lo = 16'($urandom);
      bus(1'b1, RW_IDX[i % 4], lo[7:0]);
      bus(1'b0, RW_IDX[i % 4], 8'h00);
      chk(got, 32'(lo[7:0] & RW_MSK[i % 4]));
    end
    bus(1'b1, 6'h3F, 8'hFF);
    bus(1'b0, 6'h3F, 8'h00);
    chk(got, 32'h0000_0000);
    wr16(`ADW_IDX_RES_LO, 16'hFFFF);
    rd16(`ADW_IDX_RES_LO);
    chk(32'(v), 32'h0000_0000);
    bus(1'b1, `ADW_IDX_CTRL, 8'h01);
    bus(1'b1, `ADW_IDX_IRQEN, 8'h03);
    bus(1'b1, `ADW_IDX_DBG, 8'h00);
    bus(1'b1, `ADW_IDX_EVCTL, 8'h00);
    pulse_ev(1'b0);
    bus(1'b1, `ADW_IDX_EVCTL, 8'h01);
    for (int i = 0; i < 25; i++) begin
      lo = (i == 24) ? 16'hFFFF : 16'($urandom);
      hi = (i == 1) ? 16'hFFFF : 16'($urandom);
      wr16(`ADW_IDX_WLO_LO, lo);
      wr16(`ADW_IDX_WHI_LO, hi);
      rd16(`ADW_IDX_WHI_LO);
      chk(32'(v), 32'(hi));
      bus(1'b0, `ADW_IDX_TEMP, 8'h00);
      chk(got, 32'(hi[15:8]));
      rd16(`ADW_IDX_WLO_LO);
      chk(32'(v), 32'(lo));
      conv((i == 24) ? 3'h1 : 3'(i), 3'(i / 3));
    end
    bus(1'b1, `ADW_IDX_FLAGS, 8'h00);
    bus(1'b0, `ADW_IDX_FLAGS, 8'h00);
    chk(got, 32'h0000_0003);
    bus(1'b1, `ADW_IDX_IRQEN, 8'h02);
    @(negedge clk);
    chk_bit(irq_r, 1'b0);
    chk_bit(irq_w, 1'b1);
    bus(1'b1, `ADW_IDX_FLAGS, 8'h01);
    bus(1'b0, `ADW_IDX_FLAGS, 8'h00);
    chk(got, 32'h0000_0002);
    bus(1'b1, `ADW_IDX_IRQEN, 8'h01);
    @(negedge clk);
    chk_bit(irq_w, 1'b0);
    bus(1'b1, `ADW_IDX_FLAGS, 8'h02);
    bus(1'b0, `ADW_IDX_FLAGS, 8'h00);
    chk(got, 32'h0000_0000);
    bus(1'b1, `ADW_IDX_IRQEN, 8'h03);
    @(posedge clk);
    halt <= 1'b1;
    @(negedge clk);
    chk_bit(freeze, 1'b1);
    pulse_ev(1'b0);
    bus(1'b1, `ADW_IDX_DBG, 8'h01);
    @(negedge clk);
    chk_bit(freeze, 1'b0);
    conv(3'h0, 3'h2);
    finish_test();
  end
endmodule // tb_adw_regs
